/* cpm_pkg.sv */
// Constants, types and register map of the programming model and address unit
// Operation
// RULE_01: Sixteen 32-bit general registers, eight data and eight address, plus program counter.
// RULE_02: Data registers take bit, field, byte, long and quad operations; the code gives byte, word and long writes only.
// RULE_03: Address registers serve as bases or stacks; only word and long writes.
// RULE_04: Any of the sixteen registers can be the index operand.
// RULE_05: Three separate stack pointers: user, interrupt and master.
// RULE_06: Status word holds a three-bit priority mask and five condition flags.
// RULE_07: Status word holds two trace bits, privilege bit and master bit.
// RULE_08: Every-instruction trace bit requests a trap after each retired instruction.
// RULE_09: Flow trace bit requests a trap only after change-of-flow instructions.
// RULE_10: Exception table base register places the vector table at run time.
// RULE_11: Every bus cycle drives a space code: supervisor/user, program/data.
// RULE_12: Source and destination space codes let supervisor reach user spaces.
// RULE_13: Cache control register steers and reports cache; address register holds its address.
// RULE_14: Indirect forms: plain, postincrement, predecrement, 16-bit displacement, indexed.
// RULE_15: 8 and 16 bit displacements are sign-extended; absent ones count zero.
// RULE_16: Index taken as word or long, scaled by 1, 2, 4 or 8.
// RULE_17: Base displacement is a signed 16 or 32 bit value.
// RULE_18: Memory indirect fetches a long pointer; pre or post indexing.
// RULE_19: Outer displacement is added after any memory indirection.
// RULE_20: Program counter modes offer the same options with the counter as base.
// RULE_21: Immediates of 8, 16 or 32 bits come from the instruction stream.
// RULE_22: Active stack pointer follows privilege and master bits.
// RULE_23: Absolute short sign-extends 16 bits; absolute long uses 32 bits.
package cpm_pkg;
  // Register byte offsets on the bus
  localparam logic [11:0] CPM_OFF_DATA   = 12'h000; // 8 words
  localparam logic [11:0] CPM_OFF_ADDR   = 12'h020; // 8 words, index 7 is active stack
  localparam logic [11:0] CPM_OFF_USP    = 12'h040;
  localparam logic [11:0] CPM_OFF_ISP    = 12'h044;
  localparam logic [11:0] CPM_OFF_MSP    = 12'h048;
  localparam logic [11:0] CPM_OFF_PC     = 12'h04C;
  localparam logic [11:0] CPM_OFF_STAT   = 12'h050;
  localparam logic [11:0] CPM_OFF_VBASE  = 12'h054;
  localparam logic [11:0] CPM_OFF_SRCSC  = 12'h058;
  localparam logic [11:0] CPM_OFF_DSTSC  = 12'h05C;
  localparam logic [11:0] CPM_OFF_ICCTL  = 12'h060;
  localparam logic [11:0] CPM_OFF_ICADR  = 12'h064;
  localparam logic [11:0] CPM_OFF_EACMD  = 12'h070;
  localparam logic [11:0] CPM_OFF_EXT0   = 12'h074;
  localparam logic [11:0] CPM_OFF_EXT1   = 12'h078;
  localparam logic [11:0] CPM_OFF_EARES  = 12'h07C;
  localparam logic [11:0] CPM_OFF_PTR    = 12'h080;
  localparam logic [11:0] CPM_OFF_EVENT  = 12'h084;
  localparam logic [11:0] CPM_OFF_WSIZE  = 12'h088;
  // Status word field positions
  localparam int CPM_SW_T1  = 15;
  localparam int CPM_SW_T0  = 14;
  localparam int CPM_SW_S   = 13;
  localparam int CPM_SW_M   = 12;
  localparam int CPM_SW_IPL = 8;
  localparam logic [15:0] CPM_SW_MASK  = 16'hF71F;
  localparam logic [15:0] CPM_SW_RESET = 16'h2700;
  // Cache control writable bits
  localparam logic [31:0] CPM_IC_MASK  = 32'h0000_000F;
  localparam logic [31:0] CPM_RST_WORD = 32'h0000_0000;
  // Address space codes
  localparam logic [2:0] CPM_SC_UDATA = 3'h1;
  localparam logic [2:0] CPM_SC_UPROG = 3'h2;
  localparam logic [2:0] CPM_SC_SDATA = 3'h5;
  localparam logic [2:0] CPM_SC_SPROG = 3'h6;
  // Write sizes for data and address registers
  localparam logic [1:0] CPM_SZ_BYTE = 2'h0;
  localparam logic [1:0] CPM_SZ_WORD = 2'h1;
  localparam logic [1:0] CPM_SZ_LONG = 2'h2;
  // Address computation modes
  typedef enum logic [3:0] {
    CPM_EA_IND, CPM_EA_POSTINC, CPM_EA_PREDEC, CPM_EA_DISP16, CPM_EA_IDX8,
    CPM_EA_IDXBD, CPM_EA_MIPOST, CPM_EA_MIPRE, CPM_EA_ABSW, CPM_EA_ABSL, CPM_EA_IMM
  } cpm_mode_t;
  // Address unit states
  typedef enum logic [2:0] {
    CPM_ST_IDLE  = 3'b001,
    CPM_ST_FETCH = 3'b010,
    CPM_ST_DONE  = 3'b100
  } cpm_state_t;
endpackage : cpm_pkg

/* cpm_core.sv */
// Programming model register file with effective address unit over APB
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cpm_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus cycle space code
  input  wire logic        bus_cycle,
  input  wire logic        bus_is_prog,
  input  wire logic        bus_alt_src,
  input  wire logic        bus_alt_dst,
  output logic      [2:0]  space_code_outputs,
  // Pointer fetch for memory indirection
  output logic             ptr_req,
  output logic      [31:0] ptr_addr,
  input  wire logic        ptr_ack,
  input  wire logic [31:0] ptr_data,
  // Trace
  output logic             trace_trap
);
  import cpm_pkg::*;

  logic [31:0] data_regs [8];
  logic [31:0] addr_regs [7];
  logic [31:0] usp_q, isp_q, msp_q, pc_q, vbase_q, icctl_q, icadr_q;
  logic [15:0] stat_q;
  logic [2:0]  srcsc_q, dstsc_q;
  logic [31:0] cmd_q, ext0_q, ext1_q, eares_q, ptr_q;
  logic [1:0]  wsize_q;
  logic        done_q;
  cpm_state_t  state_q;
  logic        trace_q;

  logic        wr, rd;
  logic [31:0] wmask;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;

  // Byte lane mask from strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // Merge a write into a word with strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Sized register write: bytes, words or longs
  function automatic logic [31:0] sized(input logic [31:0] old, input logic [31:0] nw, input logic [1:0] sz);
    unique case (sz)
      CPM_SZ_BYTE: sized = {old[31:8], nw[7:0]};
      CPM_SZ_WORD: sized = {old[31:16], nw[15:0]};
      default:     sized = nw;
    endcase
  endfunction : sized

  // Active stack pointer by privilege and master state
  logic        sup, mst;
  logic [31:0] sp_act;
  assign sup = stat_q[CPM_SW_S];
  assign mst = stat_q[CPM_SW_M];
  assign sp_act = !sup ? usp_q : (mst ? msp_q : isp_q); // RULE_22 RULE_05

  // Any of the sixteen registers read by number
  function automatic logic [31:0] gpr(input logic [3:0] n, input logic [31:0] spv);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (!n[3]) v = data_regs[n[2:0]];
    else if (n[2:0] == 3'h7) v = spv;
    else v = addr_regs[n[2:0]];
    gpr = v;
  endfunction : gpr

  // Command word fields
  cpm_mode_t   mode;
  logic [2:0]  base_n;
  logic        use_pc, idx_long, bd_long, od_long, bd_none, od_none, go;
  logic [3:0]  idx_n;
  logic [1:0]  scale, isz;
  assign mode     = cpm_mode_t'(cmd_q[3:0]);
  assign base_n   = cmd_q[6:4];
  assign use_pc   = cmd_q[7];
  assign idx_n    = cmd_q[11:8];
  assign idx_long = cmd_q[12];
  assign scale    = cmd_q[14:13];
  assign bd_long  = cmd_q[15];
  assign od_long  = cmd_q[16];
  assign bd_none  = cmd_q[17];
  assign od_none  = cmd_q[18];
  assign isz      = cmd_q[20:19];
  assign go       = wr && paddr == CPM_OFF_EACMD && pwdata[31];

  // Operand arithmetic
  logic [31:0] base, idx_raw, idx_val, idx_sc, d8, d16, bd, od, pre_ea, step;
  assign base    = use_pc ? pc_q : gpr({1'b1, base_n}, sp_act); // RULE_20 RULE_14
  // Index register fetched once, then sized as word or long
  assign idx_raw = gpr(idx_n, sp_act); // RULE_04
  assign idx_val = idx_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]}; // RULE_16
  assign idx_sc  = idx_val << scale; // RULE_16
  assign d8      = {{24{ext0_q[7]}}, ext0_q[7:0]}; // RULE_15
  assign d16     = {{16{ext0_q[15]}}, ext0_q[15:0]}; // RULE_15
  assign bd      = bd_none ? 32'h0000_0000 : (bd_long ? ext0_q : d16); // RULE_17
  assign od      = od_none ? 32'h0000_0000 : (od_long ? ext1_q : {{16{ext1_q[15]}}, ext1_q[15:0]}); // RULE_19
  assign step    = (isz == CPM_SZ_BYTE) ? 32'h0000_0001 : ((isz == CPM_SZ_WORD) ? 32'h0000_0002 : 32'h0000_0004);
  assign pre_ea  = base + bd + ((mode == CPM_EA_MIPRE) ? idx_sc : 32'h0000_0000); // RULE_18

  // Address unit state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CPM_ST_IDLE;
      eares_q <= CPM_RST_WORD;
      ptr_q   <= CPM_RST_WORD;
      done_q  <= 1'b0;
    end else begin
      unique case (state_q)
        // Command lands in cmd_q on this edge, so the sum waits one cycle
        CPM_ST_IDLE: if (go) begin
          done_q <= 1'b0;
          if (cpm_mode_t'(pwdata[3:0]) inside {CPM_EA_MIPOST, CPM_EA_MIPRE}) state_q <= CPM_ST_FETCH;
          else state_q <= CPM_ST_DONE;
        end
        CPM_ST_FETCH: if (ptr_ack) begin
          ptr_q   <= ptr_data;
          eares_q <= ptr_data + od + ((mode == CPM_EA_MIPOST) ? idx_sc : 32'h0000_0000); // RULE_18 RULE_19
          state_q <= CPM_ST_DONE;
        end
        // Sum from the stored command; indirect forms already hold theirs
        CPM_ST_DONE: begin
          done_q  <= 1'b1;
          state_q <= CPM_ST_IDLE;
          unique case (mode)
            CPM_EA_IND, CPM_EA_POSTINC: eares_q <= base;
            CPM_EA_PREDEC: eares_q <= base - step; // RULE_14
            CPM_EA_DISP16: eares_q <= base + d16;
            CPM_EA_IDX8:   eares_q <= base + d8 + idx_sc;
            CPM_EA_IDXBD:  eares_q <= base + bd + idx_sc;
            CPM_EA_MIPOST, CPM_EA_MIPRE: eares_q <= eares_q;
            CPM_EA_ABSW:   eares_q <= d16; // RULE_23
            CPM_EA_ABSL:   eares_q <= ext0_q; // RULE_23
            CPM_EA_IMM: begin
              unique case (isz) // RULE_21
                CPM_SZ_BYTE: eares_q <= {24'h00_0000, ext0_q[7:0]};
                CPM_SZ_WORD: eares_q <= {16'h0000, ext0_q[15:0]};
                default:     eares_q <= ext0_q;
              endcase
            end
            default: eares_q <= base;
          endcase
        end
      endcase
    end
  end
  assign ptr_req  = state_q == CPM_ST_FETCH;
  assign ptr_addr = pre_ea;

  // Command and extension words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= CPM_RST_WORD;
      ext0_q <= CPM_RST_WORD;
      ext1_q <= CPM_RST_WORD;
      wsize_q <= CPM_SZ_LONG;
    end else if (wr) begin
      if (paddr == CPM_OFF_EACMD && state_q == CPM_ST_IDLE) cmd_q <= merge(cmd_q, pwdata, wmask);
      if (paddr == CPM_OFF_EXT0) ext0_q <= merge(ext0_q, pwdata, wmask);
      if (paddr == CPM_OFF_EXT1) ext1_q <= merge(ext1_q, pwdata, wmask);
      if (paddr == CPM_OFF_WSIZE) wsize_q <= pwdata[1:0];
    end
  end

  // Data registers with sized writes
  generate
    for (genvar g = 0; g < 8; g++) begin : g_data
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) data_regs[g] <= CPM_RST_WORD; // RULE_01
        else if (wr && paddr == CPM_OFF_DATA + 12'(g * 4))
          data_regs[g] <= sized(data_regs[g], merge(data_regs[g], pwdata, wmask), wsize_q); // RULE_02
      end
    end
    for (genvar g = 0; g < 7; g++) begin : g_addr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) addr_regs[g] <= CPM_RST_WORD;
        else if (wr && paddr == CPM_OFF_ADDR + 12'(g * 4))
          addr_regs[g] <= (wsize_q == CPM_SZ_WORD) ? {{16{pwdata[15]}}, pwdata[15:0]} : pwdata; // RULE_03
        else if (done_q == 1'b0 && state_q == CPM_ST_DONE && !use_pc && base_n == 3'(g)) begin
          if (mode == CPM_EA_POSTINC) addr_regs[g] <= base + step; // RULE_14
          else if (mode == CPM_EA_PREDEC) addr_regs[g] <= base - step;
        end
      end
    end
  endgenerate

  // Stack pointers and counter
  logic sp_upd;
  assign sp_upd = state_q == CPM_ST_DONE && !done_q && !use_pc && base_n == 3'h7 &&
                  (mode == CPM_EA_POSTINC || mode == CPM_EA_PREDEC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usp_q <= CPM_RST_WORD;
      isp_q <= CPM_RST_WORD;
      msp_q <= CPM_RST_WORD;
      pc_q  <= CPM_RST_WORD;
    end else begin
      if (wr && paddr == CPM_OFF_USP) usp_q <= pwdata; // RULE_05
      if (wr && paddr == CPM_OFF_ISP) isp_q <= pwdata;
      if (wr && paddr == CPM_OFF_MSP) msp_q <= pwdata;
      if (wr && paddr == CPM_OFF_PC)  pc_q  <= pwdata; // RULE_01
      if (sp_upd) begin
        if (!sup) usp_q <= (mode == CPM_EA_POSTINC) ? base + step : base - step;
        else if (mst) msp_q <= (mode == CPM_EA_POSTINC) ? base + step : base - step;
        else isp_q <= (mode == CPM_EA_POSTINC) ? base + step : base - step;
      end
    end
  end

  // Status word, table base, space codes and cache registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q  <= CPM_SW_RESET;
      vbase_q <= CPM_RST_WORD;
      srcsc_q <= 3'h0;
      dstsc_q <= 3'h0;
      icctl_q <= CPM_RST_WORD;
      icadr_q <= CPM_RST_WORD;
    end else if (wr) begin
      if (paddr == CPM_OFF_STAT)  stat_q  <= pwdata[15:0] & CPM_SW_MASK; // RULE_06 RULE_07
      if (paddr == CPM_OFF_VBASE) vbase_q <= merge(vbase_q, pwdata, wmask); // RULE_10
      if (paddr == CPM_OFF_SRCSC) srcsc_q <= pwdata[2:0]; // RULE_12
      if (paddr == CPM_OFF_DSTSC) dstsc_q <= pwdata[2:0]; // RULE_12
      if (paddr == CPM_OFF_ICCTL) icctl_q <= pwdata & CPM_IC_MASK; // RULE_13
      if (paddr == CPM_OFF_ICADR) icadr_q <= pwdata; // RULE_13
    end
  end

  // Trace trap: instruction retire and flow events written by software
  logic ev_instr, ev_flow;
  assign ev_instr = wr && paddr == CPM_OFF_EVENT && pwdata[0];
  assign ev_flow  = wr && paddr == CPM_OFF_EVENT && pwdata[0] && pwdata[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) trace_q <= 1'b0;
    else trace_q <= (stat_q[CPM_SW_T0] && ev_instr) || (stat_q[CPM_SW_T1] && ev_flow); // RULE_08 RULE_09
  end
  assign trace_trap = trace_q;

  // Space code for each bus cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) space_code_outputs <= 3'h0;
    else if (bus_cycle) begin
      if (sup && bus_alt_src) space_code_outputs <= srcsc_q; // RULE_12
      else if (sup && bus_alt_dst) space_code_outputs <= dstsc_q;
      else if (sup) space_code_outputs <= bus_is_prog ? CPM_SC_SPROG : CPM_SC_SDATA; // RULE_11
      else space_code_outputs <= bus_is_prog ? CPM_SC_UPROG : CPM_SC_UDATA;
    end
  end

  // Read mux and unmapped address error
  logic [31:0] rd_d;
  logic        hit;
  always_comb begin
    rd_d = 32'h0000_0000;
    hit  = 1'b1;
    if (paddr < CPM_OFF_ADDR && paddr[1:0] == 2'b00) rd_d = data_regs[paddr[4:2]];
    else if (paddr >= CPM_OFF_ADDR && paddr < CPM_OFF_USP && paddr[1:0] == 2'b00)
      rd_d = gpr({1'b1, paddr[4:2]}, sp_act);
    else begin
      unique case (paddr)
        CPM_OFF_USP:   rd_d = usp_q;
        CPM_OFF_ISP:   rd_d = isp_q;
        CPM_OFF_MSP:   rd_d = msp_q;
        CPM_OFF_PC:    rd_d = pc_q;
        CPM_OFF_STAT:  rd_d = {16'h0000, stat_q};
        CPM_OFF_VBASE: rd_d = vbase_q;
        CPM_OFF_SRCSC: rd_d = {29'h0000_0000, srcsc_q};
        CPM_OFF_DSTSC: rd_d = {29'h0000_0000, dstsc_q};
        CPM_OFF_ICCTL: rd_d = icctl_q;
        CPM_OFF_ICADR: rd_d = icadr_q;
        CPM_OFF_EACMD: rd_d = {done_q, 10'h000, cmd_q[20:0]};
        CPM_OFF_EXT0:  rd_d = ext0_q;
        CPM_OFF_EXT1:  rd_d = ext1_q;
        CPM_OFF_EARES: rd_d = eares_q;
        CPM_OFF_PTR:   rd_d = ptr_q;
        CPM_OFF_EVENT: rd_d = 32'h0000_0000;
        CPM_OFF_WSIZE: rd_d = {30'h0000_0000, wsize_q};
        default:       hit  = 1'b0;
      endcase
    end
  end
  assign pslverr = psel & penable & ~hit;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rd_d;
  end

  // Checks
  a_sp_select: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
    sp_upd && sup && !mst |=> usp_q == $past(usp_q) && msp_q == $past(msp_q) && isp_q != $past(isp_q))
    else $error("stack select wrong");
  a_code_held: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    !bus_cycle |=> $stable(space_code_outputs)) else $error("space code moved without bus cycle");
  a_code_user: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    bus_cycle && !sup |=> space_code_outputs == ($past(bus_is_prog) ? CPM_SC_UPROG : CPM_SC_UDATA))
    else $error("user space code wrong");
  a_trace_all: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    stat_q[CPM_SW_T0] && ev_instr |=> trace_trap) else $error("trace trap missed");
  a_trace_flow: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    !stat_q[CPM_SW_T0] && stat_q[CPM_SW_T1] && ev_instr && !ev_flow |=> !trace_trap)
    else $error("flow trace on plain step");
  a_fetch_wait: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    ptr_req && !ptr_ack |=> ptr_req) else $error("pointer request dropped");
  a_stat_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    (stat_q & ~CPM_SW_MASK) == 16'h0000) else $error("status reserved bits set");
  a_space_alt: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    bus_cycle && sup && bus_alt_src |=> space_code_outputs == $past(srcsc_q)) else $error("alt source code wrong");
  a_done_seq: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    state_q == CPM_ST_DONE |=> state_q == CPM_ST_IDLE ##0 done_q) else $error("done not reported");
endmodule : cpm_core

/* cpm_mem_model.sv */
// Memory subsystem model answering pointer fetches
`timescale 1ns/1ps
module cpm_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Pointer fetch
  input  wire logic        ptr_req,
  input  wire logic [31:0] ptr_addr,
  output logic             ptr_ack,
  output logic      [31:0] ptr_data,
  // Answer delay in cycles
  input  wire logic [3:0]  slow
);
  logic [3:0] cnt_q;
  // Long pointer returned after a chosen delay, data scrambled otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 4'h0;
      ptr_ack  <= 1'b0;
      ptr_data <= 32'h0000_0000;
    end else begin
      ptr_ack <= 1'b0;
      if (ptr_req && !ptr_ack) begin
        if (cnt_q == slow) begin
          ptr_ack  <= 1'b1;
          ptr_data <= ptr_addr + 32'h0001_0000;
          cnt_q    <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else begin
        ptr_data <= ~ptr_data;
      end
    end
  end
endmodule : cpm_mem_model

/* cpm_core_tb.sv */
// Self-checking bench for the register file and address unit
`timescale 1ns/1ps
module cpm_core_tb;
  import cpm_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic        bus_cycle, bus_is_prog, bus_alt_src, bus_alt_dst, ptr_req, ptr_ack, trace_trap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ptr_addr, ptr_data, rd;
  logic [3:0]  pstrb, slow;
  logic [2:0]  space_code_outputs;
  int          err_count, checked;
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  cpm_core dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_cycle(bus_cycle), .bus_is_prog(bus_is_prog), .bus_alt_src(bus_alt_src), .bus_alt_dst(bus_alt_dst),
    .space_code_outputs(space_code_outputs), .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ptr_ack(ptr_ack),
    .ptr_data(ptr_data), .trace_trap(trace_trap));
  cpm_mem_model mem (.clk(clk), .rst_n(rst_n), .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ptr_ack(ptr_ack),
    .ptr_data(ptr_data), .slow(slow));
  // Comparison and verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // One APB transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i == 16) begin err_count++; give_verdict(); end
  endtask : apb
  // Start the address unit, poll done, leave result in rd
  task ea(input logic [31:0] cmd, input logic [31:0] e0, input logic [31:0] e1);
    int i;
    apb(1'b1, CPM_OFF_EXT0, e0);
    apb(1'b1, CPM_OFF_EXT1, e1);
    apb(1'b1, CPM_OFF_EACMD, cmd | 32'h8000_0000);
    for (i = 0; i < 40; i++) begin
      apb(1'b0, CPM_OFF_EACMD, 32'h0000_0000);
      if (rd[31] === 1'b1) break;
    end
    if (i == 40) begin err_count++; give_verdict(); end
    apb(1'b0, CPM_OFF_EARES, 32'h0000_0000);
  endtask : ea
  task t_reset;
    apb(1'b0, CPM_OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_2700);
    apb(1'b0, CPM_OFF_WSIZE, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    $display("test reset done");
  endtask : t_reset
  task t_regs;
    apb(1'b1, CPM_OFF_DATA + 12'h004, 32'h1122_3344);
    apb(1'b1, CPM_OFF_WSIZE, 32'h0000_0000);
    apb(1'b1, CPM_OFF_DATA + 12'h004, 32'h0000_00AB);
    apb(1'b0, CPM_OFF_DATA + 12'h004, 32'h0000_0000);
    chk(rd, 32'h1122_33AB);
    apb(1'b1, CPM_OFF_WSIZE, 32'h0000_0001);
    apb(1'b1, CPM_OFF_ADDR + 12'h008, 32'h0000_8000);
    apb(1'b0, CPM_OFF_ADDR + 12'h008, 32'h0000_0000);
    chk(rd, 32'hFFFF_8000);
    apb(1'b1, CPM_OFF_WSIZE, 32'h0000_0002);
    apb(1'b1, CPM_OFF_VBASE, 32'h1234_5678);
    pstrb <= 4'h1;
    apb(1'b1, CPM_OFF_VBASE, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, CPM_OFF_VBASE, 32'h0000_0000);
    chk(rd, 32'h1234_56FF);
    apb(1'b1, CPM_OFF_SRCSC, 32'hFFFF_FFFE);
    apb(1'b0, CPM_OFF_SRCSC, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(1'b1, CPM_OFF_ICCTL, 32'hFFFF_FFFF);
    apb(1'b0, CPM_OFF_ICCTL, 32'h0000_0000);
    chk(rd, 32'h0000_000F);
    apb(1'b1, CPM_OFF_ICADR, 32'hCAFE_0004);
    apb(1'b0, CPM_OFF_ICADR, 32'h0000_0000);
    chk(rd, 32'hCAFE_0004);
    apb(1'b1, CPM_OFF_STAT, 32'hFFFF_FFFF);
    apb(1'b0, CPM_OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_F71F);
    apb(1'b1, 12'h03C, 32'h0000_0000);
    chk({31'h0, perr}, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({perr, rd[30:0]}, 32'h8000_0000);
    $display("test regs done");
  endtask : t_regs
  task t_stack;
    logic [31:0] sw [3];
    logic [31:0] sp [3];
    sw = '{32'h0000_2000, 32'h0000_3000, 32'h0000_0000};
    sp = '{32'h0000_0200, 32'h0000_0300, 32'h0000_0100};
    apb(1'b1, CPM_OFF_USP, 32'h0000_0100);
    apb(1'b1, CPM_OFF_ISP, 32'h0000_0200);
    apb(1'b1, CPM_OFF_MSP, 32'h0000_0300);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, CPM_OFF_STAT, sw[i]);
      apb(1'b0, 12'h03C, 32'h0000_0000);
      chk(rd, sp[i]);
    end
    $display("test stack done");
  endtask : t_stack
  // One bus cycle and its space code
  task bus(input logic p, input logic s, input logic d, input logic [2:0] exp);
    @(posedge clk);
    bus_cycle <= 1'b1; bus_is_prog <= p; bus_alt_src <= s; bus_alt_dst <= d;
    @(posedge clk);
    bus_cycle <= 1'b0; bus_alt_src <= 1'b0; bus_alt_dst <= 1'b0;
    #1 chk({29'h0, space_code_outputs}, {29'h0, exp});
  endtask : bus
  task t_space;
    apb(1'b1, CPM_OFF_SRCSC, 32'h0000_0002);
    apb(1'b1, CPM_OFF_DSTSC, 32'h0000_0001);
    apb(1'b1, CPM_OFF_STAT, 32'h0000_2700);
    bus(1'b1, 1'b0, 1'b0, 3'h6);
    bus(1'b0, 1'b0, 1'b0, 3'h5);
    bus(1'b1, 1'b1, 1'b0, 3'h2);
    bus(1'b0, 1'b0, 1'b1, 3'h1);
    apb(1'b1, CPM_OFF_STAT, 32'h0000_0000);
    bus(1'b1, 1'b0, 1'b0, 3'h2);
    bus(1'b0, 1'b1, 1'b0, 3'h1);
    apb(1'b1, CPM_OFF_STAT, 32'h0000_2700);
    $display("test space done");
  endtask : t_space
  // Retirement event, then count trap pulses
  task t_trace(input logic [31:0] sw, input logic [31:0] ev, input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0000_0000;
    apb(1'b1, CPM_OFF_STAT, sw);
    apb(1'b1, CPM_OFF_EVENT, ev);
    for (int i = 0; i < 4; i++) begin
      #1 n = n + {31'h0, trace_trap};
      @(posedge clk);
    end
    chk(n, exp);
    $display("test trace done");
  endtask : t_trace
  task t_ea;
    apb(1'b1, CPM_OFF_ADDR, 32'h0000_3000);
    apb(1'b1, CPM_OFF_ADDR + 12'h004, 32'h0000_2000);
    apb(1'b1, CPM_OFF_ADDR + 12'h008, 32'h0000_1000);
    apb(1'b1, CPM_OFF_ADDR + 12'h010, 32'h0000_0011);
    apb(1'b1, CPM_OFF_DATA + 12'h00C, 32'h0000_0002);
    apb(1'b1, CPM_OFF_PC, 32'h0000_4000);
    ea(32'h0000_0023, 32'h0000_FFF0, 32'h0000_0000);
    chk(rd, 32'h0000_0FF0);
    ea(32'h0000_6C04, 32'h0000_0080, 32'h0000_0000);
    chk(rd, 32'h0000_3008);
    ea(32'h0000_9305, 32'h0002_0000, 32'h0000_0000);
    chk(rd, 32'h0002_3002);
    ea(32'h0000_0083, 32'h0000_0100, 32'h0000_0000);
    chk(rd, 32'h0000_4100);
    ea(32'h0000_0008, 32'h0000_8000, 32'h0000_0000);
    chk(rd, 32'hFFFF_8000);
    ea(32'h0000_0009, 32'h8000_1234, 32'h0000_0000);
    chk(rd, 32'h8000_1234);
    ea(32'h0000_000A, 32'h0000_0012, 32'h0000_0000);
    chk(rd, 32'h0000_0012);
    ea(32'h0010_0021, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_1000);
    ea(32'h0008_0022, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_1002);
    apb(1'b0, CPM_OFF_ADDR + 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_1002);
    ea(32'h0000_2317, 32'h0000_0010, 32'h0000_FFFC);
    chk(rd, 32'h0001_2010);
    slow <= 4'h5;
    ea(32'h0004_2316, 32'h0000_0010, 32'h0000_FFFC);
    chk(rd, 32'h0001_2014);
    apb(1'b0, CPM_OFF_PTR, 32'h0000_0000);
    chk(rd, 32'h0001_2010);
    ea(32'h0010_0071, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0200);
    apb(1'b0, CPM_OFF_ISP, 32'h0000_0000);
    chk(rd, 32'h0000_0204);
    $display("test address unit done");
  endtask : t_ea
  // Reset, then the scenarios
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; pstrb = 4'hF; slow = 4'h0; bus_cycle = 1'b0;
    bus_is_prog = 1'b0; bus_alt_src = 1'b0; bus_alt_dst = 1'b0; err_count = 0; checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_stack();
    t_space();
    t_trace(32'h0000_6700, 32'h0000_0001, 32'h0000_0001);
    t_trace(32'h0000_A700, 32'h0000_0001, 32'h0000_0000);
    t_trace(32'h0000_A700, 32'h0000_0003, 32'h0000_0001);
    t_trace(32'h0000_2700, 32'h0000_0003, 32'h0000_0000);
    t_ea();
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : cpm_core_tb
